// *** hdl/gpio_line_control_pkg.sv ***
// constants, register map and types for the four-line gpio controller
// Function
// - a selector picks line zero to three; per-line accesses touch only that line
// - each line holds a direction: input samples pin, output drives pin
// - each line holds an inversion bit acting in both directions
// - read-only bit returns selected line's present level, no side effect
// - read-only packed word, bit n is status of line n
// - per line, software picks which filter kind the width access configures
// - a width in microseconds is stored per line and filter kind and applied
// - per line source selection, effective only while line is an output
// - per line read-only circuit type code; writes are ignored
// - a selector picks which user output bit the per-bit access touches
// - per-bit write sets selected user bit one or zero; read returns it
// - packed word with bit n equal to user output n
// - deglitch reports a new level only after it persisted the width
// - debounce passes the first edge, then ignores changes for the width
// - deglitch stage runs first and feeds the debounce stage
// - sources: off, lines, user outputs, counters, logic blocks, exposure, trigger, pps, serial
package gpio_line_control_pkg;
  localparam int unsigned LINE_COUNT = 4;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WIDTH_W = 16;
  // register offsets (word indices, one word each)
  localparam logic [ADDR_W-1:0] OFS_PIN_PICK = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PIN_DIRECTION = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_PIN_POLARITY_FLIP = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL_READBACK = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_PACKED_LINE_LEVELS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_FILTER_KIND_PICK = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_FILTER_WINDOW_US = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_PIN_DRIVE_ORIGIN = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_PIN_CIRCUIT_TYPE = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_SOFT_BIT_PICK = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_SOFT_BIT_LEVEL = 4'ha;
  localparam logic [ADDR_W-1:0] OFS_PACKED_USER_OUTPUTS = 4'hb;
  // field layout
  localparam int unsigned SEL_W = 2;
  localparam int unsigned SRC_W = 4;
  // reset values
  localparam logic [WIDTH_W-1:0] FILTER_WIDTH_RST = 16'h0000;
  localparam logic [LINE_COUNT-1:0] USER_OUT_RST = 4'h0;
  // timebase: one microsecond at 20 MHz
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned US_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  // direction and filter kind codes
  localparam logic DIR_INPUT = 1'b0;
  localparam logic DIR_OUTPUT = 1'b1;
  localparam logic KIND_DEGLITCH = 1'b0;
  localparam logic KIND_DEBOUNCE = 1'b1;
  // circuit type codes
  localparam logic [1:0] FMT_TRISTATE = 2'h0;
  localparam logic [1:0] FMT_OPEN_DRAIN = 2'h1;
  // drive origin codes
  typedef enum logic [SRC_W-1:0] {
    SRC_OFF = 4'h0, SRC_LINE0 = 4'h1, SRC_LINE1 = 4'h2, SRC_LINE2 = 4'h3, SRC_LINE3 = 4'h4,
    SRC_USER0 = 4'h5, SRC_USER1 = 4'h6, SRC_USER2 = 4'h7, SRC_USER3 = 4'h8,
    SRC_COUNTER0 = 4'h9, SRC_COUNTER1 = 4'ha, SRC_LOGIC0 = 4'hb, SRC_LOGIC1 = 4'hc,
    SRC_EXPOSING = 4'hd, SRC_TRIG_READY = 4'he, SRC_PPS = 4'hf
  } drive_origin_t;
  // serial transmit has no room in four bits alone, so codes use a fifth bit below
  localparam logic [SRC_W:0] SRC_SERIAL_TX = 5'h10;
  // debounce state per line
  typedef enum logic [1:0] {
    DB_IDLE = 2'b01,
    DB_HOLD = 2'b10
  } debounce_state_t;
endpackage : gpio_line_control_pkg

// *** hdl/gpio_line_control.sv ***
// four-line gpio direction, polarity, filter and source control with register port
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module gpio_line_control
  import gpio_line_control_pkg::*;
#(
  parameter int unsigned LINES = LINE_COUNT,
  parameter logic [2*LINE_COUNT-1:0] CIRCUIT_TYPES = 8'h55
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // pins, split into input, output and enable
  input wire logic [LINES-1:0] pin_i,
  output logic [LINES-1:0] pin_o,
  output logic [LINES-1:0] pin_oe_o,
  // internal sources that may be driven out
  input wire logic [1:0] counter_active_i,
  input wire logic [1:0] logic_block_i,
  input wire logic sensor_exposing_flag_i,
  input wire logic trigger_ready_flag_i,
  input wire logic pulse_per_second_i,
  input wire logic serial_tx_i,
  // line status for the rest of the device: filtered, polarity-corrected input, or driven output
  output logic [LINES-1:0] line_level_o,
  output logic [LINES-1:0] user_out_o
);

  // register map, one word per index, every field in the low bits:
  //   0 line pick, 1 direction (1 = output), 2 inversion, 3 level of the picked line (read only)
  //   4 packed line levels (read only), 5 filter kind (0 deglitch, 1 debounce)
  //   6 filter width in microseconds for the picked line and kind
  //   7 drive origin, 8 circuit type (read only), 9 user bit pick
  //   a user bit level, b packed user bits
  // read data stand only in the cycle after the strobe and the port never stalls the master;
  // writes to read-only indices and unmapped indices are dropped without any trace

  logic [SEL_W-1:0] pin_pick_q;
  logic [SEL_W-1:0] soft_bit_pick_q;
  logic [LINES-1:0] dir_q;
  logic [LINES-1:0] flip_q;
  logic [LINES-1:0] kind_q;
  logic [LINES-1:0] user_q;
  logic [SRC_W:0] origin_q [LINES];
  logic [WIDTH_W-1:0] glitch_w_q [LINES];
  logic [WIDTH_W-1:0] bounce_w_q [LINES];
  logic [4:0] us_cnt_q;
  logic us_tick;
  logic [LINES-1:0] status;
  logic [LINES-1:0] drive;
  logic wr_line;

  // sized compare helper used by every write decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign wr_line = wr_i;
  assign us_tick = (us_cnt_q == 5'(US_CYCLES - 1));

  // microsecond timebase: the filters count ticks, not clocks, so widths stay in us
  // one divider is shared, so a line meets its first tick at any phase of its wait
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      us_cnt_q <= 5'h00;
    else if (us_tick)
      us_cnt_q <= 5'h00;
    else
      us_cnt_q <= us_cnt_q + 5'h01;
  end

  // selectors
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_pick_q <= 2'h0;
      soft_bit_pick_q <= 2'h0;
    end
    else if (wr_i)
    begin
      if (hit(addr_i, OFS_PIN_PICK))
        pin_pick_q <= wdata_i[SEL_W-1:0];
      if (hit(addr_i, OFS_SOFT_BIT_PICK))
        soft_bit_pick_q <= wdata_i[SEL_W-1:0];
    end
  end

  // direction per line; lines leave reset as inputs so nothing is driven before software asks
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      dir_q <= {LINES{DIR_INPUT}};
    else if (wr_line && hit(addr_i, OFS_PIN_DIRECTION))
      dir_q[pin_pick_q] <= wdata_i[0];
  end

  // inversion per line, applied on both the input and the output path
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      flip_q <= '0;
    else if (wr_line && hit(addr_i, OFS_PIN_POLARITY_FLIP))
      flip_q[pin_pick_q] <= wdata_i[0];
  end

  // filter kind per line; it only steers which width the window access reaches
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      kind_q <= {LINES{KIND_DEGLITCH}};
    else if (wr_line && hit(addr_i, OFS_FILTER_KIND_PICK))
      kind_q[pin_pick_q] <= wdata_i[0];
  end

  // one width per line and filter kind; only the low sixteen bits are kept
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < LINES; i++)
      begin
        glitch_w_q[i] <= FILTER_WIDTH_RST;
        bounce_w_q[i] <= FILTER_WIDTH_RST;
      end
    end
    else if (wr_line && hit(addr_i, OFS_FILTER_WINDOW_US))
    begin
      if (kind_q[pin_pick_q] == KIND_DEBOUNCE)
        bounce_w_q[pin_pick_q] <= wdata_i[WIDTH_W-1:0];
      else
        glitch_w_q[pin_pick_q] <= wdata_i[WIDTH_W-1:0];
    end
  end

  // drive origin per line; the whole word is judged, so a large code is dropped, not aliased
  // circuit type is not decoded anywhere here, so a write to it is simply lost
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < LINES; i++)
        origin_q[i] <= {1'b0, SRC_OFF};
    end
    else if (wr_line && hit(addr_i, OFS_PIN_DRIVE_ORIGIN) && (wdata_i <= DATA_W'(SRC_SERIAL_TX)))
      origin_q[pin_pick_q] <= wdata_i[SRC_W:0];
  end

  // user output bits: per-bit and packed access; the packed write wins if both hit
  // the two offsets differ, so both strobes never hit in one cycle anyway
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      user_q <= USER_OUT_RST;
    else if (wr_i && hit(addr_i, OFS_PACKED_USER_OUTPUTS))
      user_q <= wdata_i[LINES-1:0];
    else if (wr_i && hit(addr_i, OFS_SOFT_BIT_LEVEL))
      user_q[soft_bit_pick_q] <= wdata_i[0];
  end

  // input filters: deglitch then debounce, per line
  // the debounce stage sees only the deglitch result, so noise never restarts a hold
  // a width written while a filter is busy is used from the next comparison on
  logic [LINES-1:0] glitch_q;
  logic [LINES-1:0] bounce_q;
  logic [WIDTH_W-1:0] glitch_cnt_q [LINES];
  logic [WIDTH_W-1:0] bounce_cnt_q [LINES];
  debounce_state_t db_state_q [LINES];

  for (genvar g = 0; g < LINES; g++)
  begin : g_filter
    // deglitch: a new level must be stable for the full width before it is taken
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        glitch_q[g] <= 1'b0;
        glitch_cnt_q[g] <= '0;
      end
      else if (pin_i[g] == glitch_q[g])
        glitch_cnt_q[g] <= '0;
      // the first tick can come one clock after the edge, so the level is taken at the tick
      // after the count reaches the width: never early, at most one microsecond late
      else if (glitch_cnt_q[g] >= glitch_w_q[g] && (us_tick || glitch_w_q[g] == '0))
      begin
        glitch_q[g] <= pin_i[g];
        glitch_cnt_q[g] <= '0;
      end
      else if (us_tick)
        glitch_cnt_q[g] <= glitch_cnt_q[g] + 16'h0001;
    end

    // debounce: fed by the deglitch result; first edge passes, then a hold window
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        bounce_q[g] <= 1'b0;
        bounce_cnt_q[g] <= '0;
        db_state_q[g] <= DB_IDLE;
      end
      else
      begin
        case (db_state_q[g])
          DB_IDLE:
          begin
            if (glitch_q[g] != bounce_q[g])
            begin
              bounce_q[g] <= glitch_q[g];
              bounce_cnt_q[g] <= '0;
              if (bounce_w_q[g] != '0)
                db_state_q[g] <= DB_HOLD;
            end
          end
          DB_HOLD:
          begin
            // leave only on a tick, so the hold is never shorter than the width
            if (bounce_cnt_q[g] >= bounce_w_q[g] && us_tick)
              db_state_q[g] <= DB_IDLE;
            else if (us_tick)
              bounce_cnt_q[g] <= bounce_cnt_q[g] + 16'h0001;
          end
          default:
            db_state_q[g] <= DB_IDLE;
        endcase
      end
    end
  end

  // source mux, then polarity; an input line never drives
  // the origin is kept for input lines too; it simply has no pin to reach until output
  always_comb
  begin
    for (int i = 0; i < LINES; i++)
    begin
      case (origin_q[i])
        {1'b0, SRC_LINE0}: drive[i] = status[0];
        {1'b0, SRC_LINE1}: drive[i] = status[1];
        {1'b0, SRC_LINE2}: drive[i] = status[2];
        {1'b0, SRC_LINE3}: drive[i] = status[3];
        {1'b0, SRC_USER0}: drive[i] = user_q[0];
        {1'b0, SRC_USER1}: drive[i] = user_q[1];
        {1'b0, SRC_USER2}: drive[i] = user_q[2];
        {1'b0, SRC_USER3}: drive[i] = user_q[3];
        {1'b0, SRC_COUNTER0}: drive[i] = counter_active_i[0];
        {1'b0, SRC_COUNTER1}: drive[i] = counter_active_i[1];
        {1'b0, SRC_LOGIC0}: drive[i] = logic_block_i[0];
        {1'b0, SRC_LOGIC1}: drive[i] = logic_block_i[1];
        {1'b0, SRC_EXPOSING}: drive[i] = sensor_exposing_flag_i;
        {1'b0, SRC_TRIG_READY}: drive[i] = trigger_ready_flag_i;
        {1'b0, SRC_PPS}: drive[i] = pulse_per_second_i;
        SRC_SERIAL_TX: drive[i] = serial_tx_i;
        default: drive[i] = 1'b0; // source off
      endcase
      // loop back reads the previous cycle's status register, so no combinational loop
      drive[i] = drive[i] ^ flip_q[i];
    end
  end

  // registered line status: filtered input or driven output, after inversion
  // loop back sources read this register, which keeps the source mux free of loops
  logic [LINES-1:0] status_q;
  assign status = status_q;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      status_q <= '0;
    else
      for (int i = 0; i < LINES; i++)
        status_q[i] <= (dir_q[i] == DIR_OUTPUT) ? drive[i] : (bounce_q[i] ^ flip_q[i]);
  end

  // pin drive: source selection matters only for output lines
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_o <= '0;
      pin_oe_o <= '0;
    end
    else
    begin
      for (int i = 0; i < LINES; i++)
      begin
        pin_oe_o[i] <= (dir_q[i] == DIR_OUTPUT);
        pin_o[i] <= (dir_q[i] == DIR_OUTPUT) ? drive[i] : 1'b0;
      end
    end
  end

  // level copy for the rest of the device; one cycle behind status_q, in step with its read data, so it leaves from a flop
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      line_level_o <= '0;
    else
      line_level_o <= status_q;
  end

  // user bits leave through their own flop so the port has no logic behind it
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      user_out_o <= USER_OUT_RST;
    else
      user_out_o <= user_q;
  end

  // read port: data in the cycle after the strobe only; reads change no state
  // idle cycles and unmapped indices read as zero, so an or of several slaves stays clean
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_o <= '0;
    else if (!rd_i)
      rdata_o <= '0;
    else
    begin
      case (addr_i)
        OFS_PIN_PICK: rdata_o <= DATA_W'(pin_pick_q);
        OFS_PIN_DIRECTION: rdata_o <= DATA_W'(dir_q[pin_pick_q]);
        OFS_PIN_POLARITY_FLIP: rdata_o <= DATA_W'(flip_q[pin_pick_q]);
        OFS_PIN_LEVEL_READBACK: rdata_o <= DATA_W'(status_q[pin_pick_q]);
        OFS_PACKED_LINE_LEVELS: rdata_o <= DATA_W'(status_q);
        OFS_FILTER_KIND_PICK: rdata_o <= DATA_W'(kind_q[pin_pick_q]);
        OFS_FILTER_WINDOW_US:
          rdata_o <= DATA_W'((kind_q[pin_pick_q] == KIND_DEBOUNCE) ? bounce_w_q[pin_pick_q]
                                                                    : glitch_w_q[pin_pick_q]);
        OFS_PIN_DRIVE_ORIGIN: rdata_o <= DATA_W'(origin_q[pin_pick_q]);
        OFS_PIN_CIRCUIT_TYPE: rdata_o <= DATA_W'(CIRCUIT_TYPES[2*pin_pick_q +: 2]);
        OFS_SOFT_BIT_PICK: rdata_o <= DATA_W'(soft_bit_pick_q);
        OFS_SOFT_BIT_LEVEL: rdata_o <= DATA_W'(user_q[soft_bit_pick_q]);
        OFS_PACKED_USER_OUTPUTS: rdata_o <= DATA_W'(user_q);
        default: rdata_o <= '0;
      endcase
    end
  end

endmodule : gpio_line_control

// *** bench/gpio_line_control_asserts.sv ***
// port-level assertions for the four-line gpio controller
`timescale 1ns/1ns
module gpio_line_control_asserts
  import gpio_line_control_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe_o,
  input wire logic [3:0] line_level_o,
  input wire logic [3:0] user_out_o
);
  logic [1:0] pick_q;
  logic [1:0] soft_q;
  // shadow both selectors so per-line checks know their target
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pick_q <= 2'h0;
      soft_q <= 2'h0;
    end
    else if (wr_i)
    begin
      if (addr_i == OFS_PIN_PICK) pick_q <= wdata_i[1:0];
      if (addr_i == OFS_SOFT_BIT_PICK) soft_q <= wdata_i[1:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence dir_wr_s; wr_i && addr_i == OFS_PIN_DIRECTION; endsequence
  sequence soft_wr_s; wr_i && addr_i == OFS_SOFT_BIT_LEVEL; endsequence
  sequence pack_wr_s; wr_i && addr_i == OFS_PACKED_USER_OUTPUTS; endsequence
  a_input_no_drive:
    assert property ((pin_o & ~pin_oe_o) == 4'h0) else $error("input line drives high");
  a_dir_write_lands:
    assert property (dir_wr_s |-> ##2 pin_oe_o[$past(pick_q, 2)] == $past(wdata_i[0], 2))
    else $error("direction write lost");
  a_oe_has_cause:
    assert property ($changed(pin_oe_o) |-> $past(wr_i, 2) && $past(addr_i, 2) == OFS_PIN_DIRECTION)
    else $error("enable moved without write");
  a_soft_bit_write:
    assert property (soft_wr_s |-> ##2 user_out_o[$past(soft_q, 2)] == $past(wdata_i[0], 2))
    else $error("user bit write lost");
  a_packed_user_write:
    assert property (pack_wr_s |-> ##2 user_out_o == $past(wdata_i[3:0], 2)) else $error("packed write lost");
  a_user_has_cause:
    assert property ($changed(user_out_o) |-> $past(wr_i, 2) && ($past(addr_i, 2) == OFS_SOFT_BIT_LEVEL
      || $past(addr_i, 2) == OFS_PACKED_USER_OUTPUTS)) else $error("user bits moved alone");
  a_read_data_idle:
    assert property (!rd_i |=> rdata_o == 32'h0) else $error("read data outside slot");
  a_read_no_effect:
    assert property (rd_i && !$past(wr_i) |=> $stable(user_out_o) && $stable(pin_oe_o))
    else $error("read changed state");
  a_packed_levels:
    assert property (rd_i && addr_i == OFS_PACKED_LINE_LEVELS |=> rdata_o == {28'h0, line_level_o})
    else $error("packed levels mismatch");
endmodule : gpio_line_control_asserts

bind gpio_line_control gpio_line_control_asserts chk (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .pin_o, .pin_oe_o, .line_level_o, .user_out_o);

// *** bench/gpio_far_side.sv ***
// far-side circuits: pull-ups and external drivers on the four lines
`timescale 1ns/1ns
module gpio_far_side
(
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe_o,
  input wire logic [3:0] ext_level_i,
  output logic [3:0] wire_level_o
);
  // open drain: the device only pulls low, so a driven high is the pull-up or the far driver
  assign wire_level_o = ext_level_i & ~(pin_oe_o & ~pin_o);
endmodule : gpio_far_side

// *** bench/gpio_line_control_tb_top.sv ***
// self-checking bench for the four-line gpio controller
`timescale 1ns/1ns
module gpio_line_control_tb_top
  import gpio_line_control_pkg::*;
;
  localparam logic [16:0] SRC_EXP = 17'h0b4aa;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = 4'h0;
  logic [DATA_W-1:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic [3:0] pin_i, pin_o, pin_oe_o, line_level_o, user_out_o;
  logic [3:0] ext = 4'hd;
  logic [7:0] src_v = 8'h5a;
  int bad_count = 0;
  int tests_run = 0;
  gpio_line_control uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .counter_active_i(src_v[1:0]), .logic_block_i(src_v[3:2]), .sensor_exposing_flag_i(src_v[4]),
    .trigger_ready_flag_i(src_v[5]), .pulse_per_second_i(src_v[6]), .serial_tx_i(src_v[7]),
    .line_level_o(line_level_o), .user_out_o(user_out_o));
  gpio_far_side far (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .ext_level_i(ext), .wire_level_o(pin_i));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rc(input string n, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(n, rdata_o, e);
  endtask : rc
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // a hang is cut at about forty times the expected run
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    chk("oe", 32'(pin_oe_o), 32'h0);
    rc("dir", OFS_PIN_DIRECTION, 32'h0);
    rc("flip", OFS_PIN_POLARITY_FLIP, 32'h0);
    rc("origin", OFS_PIN_DRIVE_ORIGIN, 32'h0);
    rc("user", OFS_PACKED_USER_OUTPUTS, 32'h0);
    rc("unmapped", 4'hc, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_PIN_PICK, 32'(k));
      wr(OFS_PIN_CIRCUIT_TYPE, 32'h0);
      rc("circuit", OFS_PIN_CIRCUIT_TYPE, 32'(FMT_OPEN_DRAIN));
    end
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_SOFT_BIT_PICK, 32'(k));
      wr(OFS_SOFT_BIT_LEVEL, 32'(~k & 1));
    end
    rc("user", OFS_PACKED_USER_OUTPUTS, 32'h5);
    wr(OFS_PACKED_USER_OUTPUTS, 32'ha);
    wr(OFS_SOFT_BIT_PICK, 32'h1);
    rc("bit", OFS_SOFT_BIT_LEVEL, 32'h1);
    wr(OFS_SOFT_BIT_LEVEL, 32'h0);
    rc("user", OFS_PACKED_USER_OUTPUTS, 32'h8);
    chk("user_out", 32'(user_out_o), 32'h8);
    wr(OFS_PACKED_USER_OUTPUTS, 32'h5);
    $display("test user bits done");
    // line 3 drives every origin; its own loop back is circular, so its value is not judged
    wr(OFS_PIN_PICK, 32'h3);
    wr(OFS_PIN_DIRECTION, 32'h1);
    for (int c = 0; c < 17; c++)
    begin
      wr(OFS_PIN_DRIVE_ORIGIN, 32'(c));
      repeat (8) @(posedge clk_i);
      if (c != 4) chk("drive", 32'(pin_o[3]), 32'(SRC_EXP[c]));
    end
    wr(OFS_PIN_DRIVE_ORIGIN, 32'h11);
    rc("origin", OFS_PIN_DRIVE_ORIGIN, 32'(SRC_SERIAL_TX));
    wr(OFS_PIN_POLARITY_FLIP, 32'h1);
    repeat (4) @(posedge clk_i);
    chk("flip_out", 32'({pin_oe_o[3], pin_o[3]}), 32'h3);
    src_v <= 8'hda;
    repeat (6) @(posedge clk_i);
    rc("level", OFS_PIN_LEVEL_READBACK, 32'h0);
    rc("levels", OFS_PACKED_LINE_LEVELS, 32'h5);
    wr(OFS_PIN_DIRECTION, 32'h0);
    repeat (6) @(posedge clk_i);
    chk("released", 32'({pin_oe_o[3], pin_o[3]}), 32'h0);
    rc("in_flip", OFS_PIN_LEVEL_READBACK, 32'h0);
    $display("test sources done");
    wr(OFS_PIN_PICK, 32'h1);
    wr(OFS_FILTER_WINDOW_US, 32'h2);
    rc("width", OFS_FILTER_WINDOW_US, 32'h2);
    wr(OFS_FILTER_KIND_PICK, 32'h1);
    rc("width_db", OFS_FILTER_WINDOW_US, 32'h0);
    wr(OFS_FILTER_KIND_PICK, 32'h0);
    ext <= 4'hf;
    repeat (10) @(posedge clk_i);
    ext <= 4'hd;
    repeat (60) @(posedge clk_i);
    chk("glitch", 32'(line_level_o[1]), 32'h0);
    ext <= 4'hf;
    repeat (30) @(posedge clk_i);
    chk("early", 32'(line_level_o[1]), 32'h0);
    repeat (40) @(posedge clk_i);
    chk("late", 32'(line_level_o[1]), 32'h1);
    $display("test deglitch done");
    wr(OFS_PIN_PICK, 32'h2);
    wr(OFS_FILTER_KIND_PICK, 32'h1);
    wr(OFS_FILTER_WINDOW_US, 32'h2);
    ext <= 4'hb;
    repeat (6) @(posedge clk_i);
    chk("first", 32'(line_level_o[2]), 32'h0);
    ext <= 4'hf;
    repeat (6) @(posedge clk_i);
    chk("bounce", 32'(line_level_o[2]), 32'h0);
    repeat (70) @(posedge clk_i);
    chk("settled", 32'(line_level_o[2]), 32'h1);
    $display("test debounce done");
    tally_and_finish();
  end
endmodule : gpio_line_control_tb_top
